// *** hw/lgc_pkg.sv ***
// shared constants, types and decode helpers for the line config block
package lgc_pkg;
    localparam int NUM_CH = 14;
    localparam int SEG_W = 7;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    // per-channel segment registers, channel 0 offsets and stride
    localparam logic [7:0] SEG_SIX_OFF = 8'h0d;
    localparam logic [7:0] SEG_SEVEN_OFF = 8'h0e;
    localparam logic [7:0] SEG_EIGHT_OFF = 8'h0f;
    localparam logic [7:0] CH_STRIDE = 8'h10;
    localparam logic [7:0] SEG_RST = 8'h00;
    localparam int SEG_SIGN_BIT = 6;
    // global configuration register
    localparam logic [7:0] GLOBAL_OFF = 8'he0;
    localparam logic [7:0] GLOBAL_RST = 8'h00;
    localparam int RAIL_FMT_BIT = 7;
    localparam int AUTO_ONES_BIT = 6;
    localparam int RX_EDGE_BIT = 5;
    localparam int TX_EDGE_BIT = 4;
    localparam int POL_BIT = 3;
    localparam int IRQ_EN_BIT = 1;
    localparam int SOFT_RST_BIT = 0;
    // interrupt registers, low byte channels 0-7, high byte 8-13
    localparam logic [7:0] IRQ_STAT_LO = 8'hf0;
    localparam logic [7:0] IRQ_STAT_HI = 8'hf1;
    localparam logic [7:0] IRQ_EN_LO = 8'hf2;
    localparam logic [7:0] IRQ_EN_HI = 8'hf3;
    localparam logic [7:0] IRQ_CLR_LO = 8'hf4;
    localparam logic [7:0] IRQ_CLR_HI = 8'hf5;
    // soft reset hold time, must be exceeded
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SRST_TIME_US = 10;
    localparam int SRST_MIN = (SRST_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [11:0] SRST_CYCLES = 12'(SRST_MIN + 1);

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } lgc_bus_s;

    typedef struct packed {
        logic rail_fmt;
        logic auto_ones;
        logic rx_edge;
        logic tx_edge;
        logic pol;
        logic irq_en;
    } lgc_cfg_s;

    function automatic logic seg_hit(input logic [7:0] a);
        return (a[7:4] < 4'(NUM_CH)) && (a[3:0] >= SEG_SIX_OFF[3:0]);
    endfunction : seg_hit
endpackage : lgc_pkg

// *** hw/lgc_chan_seg.sv ***
// three arbitrary pulse segment registers of one channel
`timescale 1ns/10ps
`default_nettype none
module lgc_chan_seg (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // write from the decoder
    input wire logic wr_en,
    input wire logic [3:0] sub,
    input wire logic [6:0] wdata,
    // segment shapes and sign bits
    output logic [6:0] seg_six_shape,
    output logic [6:0] seg_seven_shape,
    output logic [6:0] seg_eight_shape,
    output logic [2:0] seg_positive
);
    import lgc_pkg::*;
    logic [6:0] six_ff, seven_ff, eight_ff;
    logic [6:0] nxt_six, nxt_seven, nxt_eight;

    always_comb begin
        nxt_six = six_ff;
        nxt_seven = seven_ff;
        nxt_eight = eight_ff;
        if (wr_en) begin
            case (sub)
                SEG_SIX_OFF[3:0]: nxt_six = wdata;
                SEG_SEVEN_OFF[3:0]: nxt_seven = wdata;
                SEG_EIGHT_OFF[3:0]: nxt_eight = wdata;
                default: nxt_six = six_ff;
            endcase
        end
    end

    // only the hardware reset clears these
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            six_ff <= SEG_RST[6:0];
            seven_ff <= SEG_RST[6:0];
            eight_ff <= SEG_RST[6:0];
        end else begin
            six_ff <= nxt_six;
            seven_ff <= nxt_seven;
            eight_ff <= nxt_eight;
        end
    end

    assign seg_six_shape = six_ff;
    assign seg_seven_shape = seven_ff;
    assign seg_eight_shape = eight_ff;
    // one means positive direction
    assign seg_positive = {eight_ff[SEG_SIGN_BIT], seven_ff[SEG_SIGN_BIT], six_ff[SEG_SIGN_BIT]};
endmodule : lgc_chan_seg
`default_nettype wire

// *** hw/lgc_soft_rst_timer.sv ***
// qualifies the soft reset bit by its hold time
`timescale 1ns/10ps
`default_nettype none
module lgc_soft_rst_timer (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // soft reset bit as written
    input wire logic hold,
    // core reset, high while qualified
    output logic core_rst
);
    import lgc_pkg::*;
    logic [11:0] cnt_ff, nxt_cnt;
    logic rst_ff, nxt_rst;

    // short glitches of the bit never reset the core
    always_comb begin
        nxt_cnt = 12'h000;
        if (hold) begin
            nxt_cnt = (cnt_ff == SRST_CYCLES) ? cnt_ff : cnt_ff + 12'h001;
        end
        nxt_rst = (nxt_cnt == SRST_CYCLES);
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= 12'h000;
            rst_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            rst_ff <= nxt_rst;
        end
    end

    assign core_rst = rst_ff;
endmodule : lgc_soft_rst_timer
`default_nettype wire

// *** hw/lgc_line_cfg.sv ***
// global line config, pulse segments six to eight, interrupt and rail path
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - per channel segment six at 0x0d-0xdd
// - per channel segment seven at 0x0e-0xde
// - per channel segment eight at 0x0f-0xdf
// - segment bit 7 unused, reads zero
// - segment top bit: one positive, zero negative
// - global bit 7: one single rail
// - bit 6: send ones on signal loss
// - bit 5: rx output edge, one falling
// - bit 4: tx sample edge, one rising
// - bit 3: one makes data active low
// - bit 1 gates every interrupt
// - bit 0 held over 10us resets core
module lgc_line_cfg (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // register port
    input wire lgc_pkg::lgc_bus_s bus,
    output logic [7:0] rdata,
    output logic irq,
    // line status and data
    input wire logic [13:0] rx_signal_loss,
    input wire logic [13:0] tx_positive_rail,
    input wire logic [13:0] tx_negative_rail,
    input wire logic [13:0] rx_pos_line,
    input wire logic [13:0] rx_neg_line,
    output logic [13:0] tx_pos_line,
    output logic [13:0] tx_neg_line,
    output logic [13:0] rx_positive_rail,
    output logic [13:0] rx_negative_rail,
    output logic [13:0] send_all_ones,
    // configuration to the line core
    output var lgc_pkg::lgc_cfg_s cfg,
    output logic soft_core_reset,
    output logic [13:0][6:0] seg_six_shape,
    output logic [13:0][6:0] seg_seven_shape,
    output logic [13:0][6:0] seg_eight_shape,
    output logic [13:0][2:0] seg_positive
);
    import lgc_pkg::*;

    logic [3:0] ch;
    logic hit_seg;
    assign ch = bus.addr[7:4];
    assign hit_seg = seg_hit(bus.addr);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            lgc_chan_seg u_seg (
                .mclk(mclk),
                .nrst(nrst),
                .wr_en(bus.wr && hit_seg && (ch == 4'(gi))),
                .sub(bus.addr[3:0]),
                .wdata(bus.wdata[6:0]),
                .seg_six_shape(seg_six_shape[gi]),
                .seg_seven_shape(seg_seven_shape[gi]),
                .seg_eight_shape(seg_eight_shape[gi]),
                .seg_positive(seg_positive[gi])
            );
        end
    endgenerate

    // global configuration
    logic [7:0] glb_ff, nxt_glb;
    always_comb begin
        nxt_glb = glb_ff;
        if (bus.wr && bus.addr == GLOBAL_OFF) begin
            nxt_glb = bus.wdata;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            glb_ff <= GLOBAL_RST;
        end else begin
            glb_ff <= nxt_glb;
        end
    end

    assign cfg.rail_fmt = glb_ff[RAIL_FMT_BIT];
    assign cfg.auto_ones = glb_ff[AUTO_ONES_BIT];
    assign cfg.rx_edge = glb_ff[RX_EDGE_BIT];
    assign cfg.tx_edge = glb_ff[TX_EDGE_BIT];
    assign cfg.pol = glb_ff[POL_BIT];
    assign cfg.irq_en = glb_ff[IRQ_EN_BIT];

    lgc_soft_rst_timer u_srst (
        .mclk(mclk),
        .nrst(nrst),
        .hold(glb_ff[SOFT_RST_BIT]),
        .core_rst(soft_core_reset)
    );

    // interrupt status, enable and clear
    logic [13:0] stat_ff, nxt_stat, ien_ff, nxt_ien, loss_d_ff, nxt_loss_d;
    logic [15:0] clr16, stat16, ien16;
    logic irq_ff, nxt_irq;
    assign stat16 = 16'(stat_ff);
    assign ien16 = 16'(ien_ff);

    always_comb begin
        clr16 = 16'h0000;
        nxt_ien = ien_ff;
        if (bus.wr) begin
            case (bus.addr)
                IRQ_CLR_LO: clr16 = {8'h00, bus.wdata};
                IRQ_CLR_HI: clr16 = {bus.wdata, 8'h00};
                IRQ_EN_LO: nxt_ien = {ien_ff[13:8], bus.wdata};
                IRQ_EN_HI: nxt_ien = {bus.wdata[5:0], ien_ff[7:0]};
                default: clr16 = 16'h0000;
            endcase
        end
        // edge detector is core logic, soft reset rearms it
        nxt_loss_d = soft_core_reset ? 14'h0000 : rx_signal_loss;
        // a new event beats a clear in the same cycle
        nxt_stat = (stat_ff & ~clr16[13:0])
            | (rx_signal_loss & ~loss_d_ff & {NUM_CH{cfg.irq_en}});
        nxt_irq = cfg.irq_en && |(nxt_stat & ien_ff);
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            stat_ff <= 14'h0000;
            ien_ff <= 14'h0000;
            loss_d_ff <= 14'h0000;
            irq_ff <= 1'b0;
        end else begin
            stat_ff <= nxt_stat;
            ien_ff <= nxt_ien;
            loss_d_ff <= nxt_loss_d;
            irq_ff <= nxt_irq;
        end
    end
    assign irq = irq_ff;

    // read data, valid only in the cycle after the strobe
    logic [7:0] rdata_ff, nxt_rdata;
    always_comb begin
        nxt_rdata = 8'h00;
        if (bus.rd) begin
            if (hit_seg) begin
                case (bus.addr[3:0])
                    SEG_SIX_OFF[3:0]: nxt_rdata = {1'b0, seg_six_shape[ch]};
                    SEG_SEVEN_OFF[3:0]: nxt_rdata = {1'b0, seg_seven_shape[ch]};
                    SEG_EIGHT_OFF[3:0]: nxt_rdata = {1'b0, seg_eight_shape[ch]};
                    default: nxt_rdata = 8'h00;
                endcase
            end else begin
                case (bus.addr)
                    GLOBAL_OFF: nxt_rdata = glb_ff;
                    IRQ_STAT_LO: nxt_rdata = stat16[7:0];
                    IRQ_STAT_HI: nxt_rdata = stat16[15:8];
                    IRQ_EN_LO: nxt_rdata = ien16[7:0];
                    IRQ_EN_HI: nxt_rdata = ien16[15:8];
                    default: nxt_rdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign rdata = rdata_ff;

    // rail path: polarity, rail format and forced ones
    logic [13:0] pol_v, tx_p, tx_n, rx_p, rx_n;
    logic [13:0] tx_positive_rail_ff, tx_negative_rail_ff, rx_positive_rail_ff, rx_negative_rail_ff, aones_ff;
    logic [13:0] nxt_tx_positive_rail, nxt_tx_negative_rail, nxt_rx_positive_rail, nxt_rx_negative_rail, nxt_aones;
    assign pol_v = {NUM_CH{cfg.pol}};

    always_comb begin
        tx_p = tx_positive_rail ^ pol_v;
        tx_n = cfg.rail_fmt ? 14'h0000 : tx_negative_rail ^ pol_v;
        rx_p = cfg.rail_fmt ? (rx_pos_line | rx_neg_line) : rx_pos_line;
        rx_n = cfg.rail_fmt ? 14'h0000 : rx_neg_line;
        nxt_aones = rx_signal_loss & {NUM_CH{cfg.auto_ones}};
        nxt_tx_positive_rail = tx_p | nxt_aones;
        nxt_tx_negative_rail = tx_n & ~nxt_aones;
        nxt_rx_positive_rail = rx_p ^ pol_v;
        nxt_rx_negative_rail = rx_n ^ (pol_v & {NUM_CH{~cfg.rail_fmt}});
        if (soft_core_reset) begin
            nxt_aones = 14'h0000;
            nxt_tx_positive_rail = 14'h0000;
            nxt_tx_negative_rail = 14'h0000;
            nxt_rx_positive_rail = 14'h0000;
            nxt_rx_negative_rail = 14'h0000;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tx_positive_rail_ff <= 14'h0000;
            tx_negative_rail_ff <= 14'h0000;
            rx_positive_rail_ff <= 14'h0000;
            rx_negative_rail_ff <= 14'h0000;
            aones_ff <= 14'h0000;
        end else begin
            tx_positive_rail_ff <= nxt_tx_positive_rail;
            tx_negative_rail_ff <= nxt_tx_negative_rail;
            rx_positive_rail_ff <= nxt_rx_positive_rail;
            rx_negative_rail_ff <= nxt_rx_negative_rail;
            aones_ff <= nxt_aones;
        end
    end
    assign tx_pos_line = tx_positive_rail_ff;
    assign tx_neg_line = tx_negative_rail_ff;
    assign rx_positive_rail = rx_positive_rail_ff;
    assign rx_negative_rail = rx_negative_rail_ff;
    assign send_all_ones = aones_ff;

    // assertion helper: held soft reset cycles, counted apart from the timer
    logic [11:0] held_ff, nxt_held;
    always_comb begin
        nxt_held = 12'h000;
        if (glb_ff[SOFT_RST_BIT]) begin
            nxt_held = (held_ff == SRST_CYCLES) ? held_ff : held_ff + 12'h001;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            held_ff <= 12'h000;
        end else begin
            held_ff <= nxt_held;
        end
    end

    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    chk_set_beats_clear: assert property (
        cfg.irq_en && |(rx_signal_loss & ~loss_d_ff)
        |=> (stat_ff & $past(rx_signal_loss & ~loss_d_ff)) == $past(rx_signal_loss & ~loss_d_ff))
        else $error("loss event lost to a clear");
    chk_irq_level: assert property (
        cfg.irq_en && |(stat_ff & ien_ff) && !bus.wr |=> irq)
        else $error("interrupt missing for enabled status");
    chk_rdata_idle: assert property (
        !bus.rd |=> rdata == 8'h00)
        else $error("read data outside read cycle");
    chk_unmapped_read: assert property (
        bus.rd && !hit_seg && bus.addr[7:4] < 4'he |=> rdata == 8'h00)
        else $error("unmapped address read not zero");
    chk_rx_single_rail: assert property (
        cfg.rail_fmt |=> rx_negative_rail == 14'h0000)
        else $error("receive negative rail active in single rail");
    chk_rx_polarity: assert property (
        !soft_core_reset && !cfg.rail_fmt
        |=> rx_positive_rail == ($past(rx_pos_line) ^ {NUM_CH{$past(cfg.pol)}}))
        else $error("receive positive polarity wrong");
    chk_rx_neg_polarity: assert property (
        !soft_core_reset && !cfg.rail_fmt
        |=> rx_negative_rail == ($past(rx_neg_line) ^ {NUM_CH{$past(cfg.pol)}}))
        else $error("receive negative polarity wrong");
    chk_srst_clears_line: assert property (
        soft_core_reset |=> tx_pos_line == 14'h0000 && send_all_ones == 14'h0000)
        else $error("soft reset left line outputs active");
    chk_srst_hold_time: assert property (
        soft_core_reset == (held_ff == SRST_CYCLES))
        else $error("soft reset not tied to hold time");
    chk_glb_write: assert property (
        bus.wr && bus.addr == GLOBAL_OFF |=> glb_ff == $past(bus.wdata))
        else $error("global register write lost");
    chk_srst_keeps_seg: assert property (
        soft_core_reset && !bus.wr |=> $stable(seg_six_shape) && $stable(seg_eight_shape))
        else $error("soft reset changed segments");

    chk_seg_six_write: assert property (
        bus.wr && hit_seg && bus.addr[3:0] == SEG_SIX_OFF[3:0]
        |=> seg_six_shape[$past(ch)] == $past(bus.wdata[6:0]))
        else $error("segment six write lost");
    chk_seg_seven_write: assert property (
        bus.wr && hit_seg && bus.addr[3:0] == SEG_SEVEN_OFF[3:0]
        |=> seg_seven_shape[$past(ch)] == $past(bus.wdata[6:0]))
        else $error("segment seven write lost");
    chk_seg_eight_write: assert property (
        bus.wr && hit_seg && bus.addr[3:0] == SEG_EIGHT_OFF[3:0]
        |=> seg_eight_shape[$past(ch)] == $past(bus.wdata[6:0]))
        else $error("segment eight write lost");
    chk_seg_bit_seven: assert property (
        bus.rd && hit_seg |=> rdata[7] == 1'b0)
        else $error("segment bit 7 not zero");
    chk_seg_sign_bit: assert property (
        bus.wr && hit_seg && bus.addr[3:0] == SEG_SIX_OFF[3:0]
        |=> seg_positive[$past(ch)][0] == $past(bus.wdata[6]))
        else $error("segment sign wrong");
    chk_single_rail_neg: assert property (
        cfg.rail_fmt && $stable(cfg.rail_fmt) |=> tx_neg_line == 14'h0000)
        else $error("negative rail active in single rail");
    chk_auto_ones_follow: assert property (
        !soft_core_reset |=> send_all_ones
            == ($past(rx_signal_loss) & {NUM_CH{$past(cfg.auto_ones)}}))
        else $error("all ones not tied to signal loss");
    chk_auto_ones_line: assert property (
        cfg.auto_ones && rx_signal_loss[0] && !soft_core_reset
        |=> tx_pos_line[0] && !tx_neg_line[0])
        else $error("all ones not on line");
    chk_tx_polarity: assert property (
        !soft_core_reset && !cfg.rail_fmt && !cfg.auto_ones
        |=> tx_pos_line == ($past(tx_positive_rail) ^ {NUM_CH{$past(cfg.pol)}}))
        else $error("transmit polarity wrong");
    chk_irq_gate_off: assert property (
        !cfg.irq_en |=> !irq)
        else $error("interrupt while globally disabled");
    chk_irq_no_new_event: assert property (
        !cfg.irq_en && !(|stat_ff) |=> !(|stat_ff))
        else $error("status set while disabled");
    chk_srst_needs_hold: assert property (
        $rose(glb_ff[SOFT_RST_BIT]) |-> !soft_core_reset [*8])
        else $error("soft reset too early");
    chk_srst_release: assert property (
        !glb_ff[SOFT_RST_BIT] |=> !soft_core_reset)
        else $error("soft reset without hold");
    chk_srst_keeps_cfg: assert property (
        soft_core_reset && !bus.wr |=> $stable(glb_ff) && $stable(ien_ff))
        else $error("soft reset changed registers");
    chk_chan13_read: assert property (
        bus.rd && bus.addr == SEG_SIX_OFF + 8'(13) * CH_STRIDE
        |=> rdata == {1'b0, $past(seg_six_shape[13])})
        else $error("channel 13 segment six readback");
    chk_glb_readback: assert property (
        bus.rd && bus.addr == GLOBAL_OFF |=> rdata == $past(glb_ff))
        else $error("global register readback");

    cov_soft_reset: cover property ($rose(soft_core_reset));
    cov_irq_raise: cover property ($rose(irq));
    cov_auto_ones: cover property ($rose(send_all_ones[13]));
    cov_single_rail: cover property (cfg.rail_fmt && |rx_pos_line);
    cov_set_and_clear: cover property (bus.wr && bus.addr == IRQ_CLR_LO && |nxt_stat[7:0]);
endmodule : lgc_line_cfg
`default_nettype wire

// *** testbench/lgc_host.sv ***
// host processor model driving the register port
`timescale 1ns/10ps
`default_nettype none
module lgc_host (
    // clock
    input wire logic mclk,
    // register port
    output var lgc_pkg::lgc_bus_s bus,
    input wire logic [7:0] rdata
);
    import lgc_pkg::*;
    initial bus = '0;
    // released lines show inverted values so a stale address never decodes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus <= '{addr: ~a, wdata: 8'h5a, wr: 1'b0, rd: 1'b0};
        #1 d = rdata;
    endtask : rd
    // waits n cycles, drives nothing, the soft reset bit stays as last written
    task automatic hold(input int n);
        repeat (n) @(posedge mclk);
    endtask : hold
endmodule : lgc_host
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the line config block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import lgc_pkg::*;
    localparam int LIMIT = 20000;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    lgc_bus_s bus;
    lgc_cfg_s cfg;
    logic [7:0] rdata, d, a, v;
    logic irq, srst;
    logic [13:0] loss = '0, tp = '0, tn = '0, rp = '0, rn = '0, pol;
    logic [13:0] txp, txn, rxp, rxn, ones;
    logic [13:0][6:0] s6, s7, s8;
    logic [13:0][2:0] sp;
    logic [7:0] mdl [int];
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;

    always #2.5 mclk = ~mclk;

    lgc_host i_lgc_host (.mclk(mclk), .bus(bus), .rdata(rdata));

    lgc_line_cfg i_lgc_line_cfg (
        .mclk(mclk), .nrst(nrst), .bus(bus), .rdata(rdata), .irq(irq),
        .rx_signal_loss(loss), .tx_positive_rail(tp), .tx_negative_rail(tn),
        .rx_pos_line(rp), .rx_neg_line(rn), .tx_pos_line(txp), .tx_neg_line(txn),
        .rx_positive_rail(rxp), .rx_negative_rail(rxn), .send_all_ones(ones),
        .cfg(cfg), .soft_core_reset(srst), .seg_six_shape(s6),
        .seg_seven_shape(s7), .seg_eight_shape(s8), .seg_positive(sp)
    );

    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    // new line stimulus, outputs are one register stage behind
    task automatic drive_lines(input logic [13:0] l);
        @(posedge mclk);
        loss <= l;
        tp <= 14'($urandom);
        tn <= 14'($urandom);
        rp <= 14'($urandom);
        rn <= 14'($urandom);
        @(posedge mclk);
        #1;
    endtask : drive_lines

    always @(posedge mclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            test_done();
        end
    end

    initial begin
        void'($urandom(20141));
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        // reset values, then random contents, bit 7 written but never stored
        for (int ch = 0; ch < NUM_CH; ch++) begin
            for (int k = 0; k < 3; k++) begin
                a = 8'(SEG_SIX_OFF + k + CH_STRIDE * ch);
                i_lgc_host.rd(a, d);
                chk("seg reset", 16'(d), 16'(SEG_RST));
                v = 8'($urandom);
                i_lgc_host.wr(a, v);
                mdl[a] = v & 8'h7f;
            end
        end
        for (int ch = 0; ch < NUM_CH; ch++) begin
            a = 8'(SEG_SIX_OFF + CH_STRIDE * ch);
            for (int k = 0; k < 3; k++) begin
                i_lgc_host.rd(8'(a + k), d);
                chk("seg read", 16'(d), 16'(mdl[a + k]));
            end
            chk("seg six", 16'(s6[ch]), 16'(mdl[a]));
            chk("seg seven", 16'(s7[ch]), 16'(mdl[a + 1]));
            chk("seg eight", 16'(s8[ch]), 16'(mdl[a + 2]));
            v = {5'h00, mdl[a + 2][6], mdl[a + 1][6], mdl[a][6]};
            chk("seg sign", 16'(sp[ch]), 16'(v));
        end
        $display("test segments done");
        // holes in the map read zero and swallow writes
        i_lgc_host.wr(8'h10, 8'h55);
        i_lgc_host.rd(8'h10, d);
        chk("unmapped", 16'(d), 16'h0000);
        i_lgc_host.rd(8'he8, d);
        chk("unmapped", 16'(d), 16'h0000);
        i_lgc_host.rd(GLOBAL_OFF, d);
        chk("global reset", 16'(d), 16'(GLOBAL_RST));
        $display("test unmapped done");
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom) & 8'h36;
            v[7] = i[0];
            v[3] = i[1];
            i_lgc_host.wr(GLOBAL_OFF, v);
            i_lgc_host.rd(GLOBAL_OFF, d);
            chk("global read", 16'(d), 16'(v));
            chk("cfg", 16'(cfg), 16'({v[7:3], v[1]}));
            drive_lines(14'h0000);
            pol = {14{v[3]}};
            chk("tx pos", 16'(txp), 16'(tp ^ pol));
            chk("tx neg", 16'(txn), 16'(v[7] ? 14'h0000 : tn ^ pol));
            chk("rx pos", 16'(rxp), 16'((v[7] ? rp | rn : rp) ^ pol));
            chk("rx neg", 16'(rxn), 16'(v[7] ? 14'h0000 : rn ^ pol));
        end
        $display("test rail format done");
        i_lgc_host.wr(GLOBAL_OFF, 8'h40);
        drive_lines(14'($urandom));
        chk("all ones", 16'(ones), 16'(loss));
        chk("tx pos", 16'(txp), 16'(tp | loss));
        chk("tx neg", 16'(txn), 16'(tn & ~loss));
        $display("test all ones done");
        drive_lines(14'h0000);
        i_lgc_host.wr(GLOBAL_OFF, 8'h02);
        i_lgc_host.wr(IRQ_EN_LO, 8'hff);
        i_lgc_host.wr(IRQ_EN_HI, 8'h3f);
        drive_lines(14'h2004);
        chk("irq", 16'(irq), 16'h0001);
        i_lgc_host.rd(IRQ_STAT_HI, d);
        chk("stat hi", 16'(d), 16'h0020);
        i_lgc_host.wr(IRQ_CLR_HI, 8'h20);
        i_lgc_host.wr(IRQ_CLR_LO, 8'h04);
        #1 chk("irq", 16'(irq), 16'h0000);
        // masked channel still latches its status
        i_lgc_host.wr(IRQ_EN_LO, 8'h00);
        drive_lines(14'h0000);
        drive_lines(14'h0004);
        chk("irq", 16'(irq), 16'h0000);
        i_lgc_host.rd(IRQ_STAT_LO, d);
        chk("stat lo", 16'(d), 16'h0004);
        i_lgc_host.wr(IRQ_CLR_LO, 8'h04);
        i_lgc_host.wr(IRQ_EN_LO, 8'hff);
        i_lgc_host.wr(GLOBAL_OFF, 8'h00);
        drive_lines(14'h0000);
        drive_lines(14'h0004);
        i_lgc_host.rd(IRQ_STAT_LO, d);
        chk("stat off", 16'(d), 16'h0000);
        chk("irq", 16'(irq), 16'h0000);
        $display("test interrupt done");
        i_lgc_host.wr(GLOBAL_OFF, 8'h01);
        // 10 us at 5 ns is 2000 cycles, the core resets on the one after
        i_lgc_host.hold(2000);
        #1 chk("soft short", 16'(srst), 16'h0000);
        i_lgc_host.hold(1);
        #1 chk("soft long", 16'(srst), 16'h0001);
        i_lgc_host.hold(1);
        #1 chk("tx cleared", 16'(txp), 16'h0000);
        chk("rx cleared", 16'(rxp), 16'h0000);
        i_lgc_host.rd(8'h5e, d);
        chk("seg kept", 16'(d), 16'(mdl[8'h5e]));
        i_lgc_host.wr(GLOBAL_OFF, 8'h00);
        @(posedge mclk);
        #1 chk("soft end", 16'(srst), 16'h0000);
        $display("test soft reset done");
        // only the reset pin restores defaults
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        i_lgc_host.rd(8'h5e, d);
        chk("seg hw reset", 16'(d), 16'(SEG_RST));
        $display("test hardware reset done");
        test_done();
    end
endmodule : testbench
`default_nettype wire
